// ==== ddt_pkg.sv ====
package ddt_pkg;

   // ----------------------------------------------------------------------
   // Termination switching figures, in link clock cycles
   // ----------------------------------------------------------------------
   localparam int ODT_MIN_HIGH_CK   = 4;  // term_enable_min_high_short
   localparam int NOM_TO_WR_SUB_CK  = 2;  // write_latency minus this
   localparam int TURNOFF_SUB_CK    = 2;  // term_turnoff_latency = write_latency - this
   localparam int WR_TO_NOM_CHOP_CK = 4;  // plus term_turnoff_latency
   localparam int WR_TO_NOM_FULL_CK = 6;  // plus term_turnoff_latency

   // ----------------------------------------------------------------------
   // Write leveling figures
   // ----------------------------------------------------------------------
   localparam int  LVL_FIRST_STROBE_CK = 40;   // leveling_first_strobe_wait
   localparam real LVL_FB_1866_NS      = 7.5;  // leveling_feedback_delay, 1866 grade
   localparam real LVL_FB_2133_NS      = 7.0;  // leveling_feedback_delay, 2133 grade
   localparam real LVL_SPREAD_NS       = 2.0;  // leveling_feedback_spread
   localparam int  PAD_SYNC_CK         = 2;    // Pad synchroniser stages ahead of the detector

   // Termination applied at the data pins
   typedef enum logic [1:0] {
      DDT_TERM_OFF,
      DDT_TERM_NOM,
      DDT_TERM_WR
   } ddt_term_t;

   // Least time to cycles: round up, never below one
   function automatic int min_cycles(input real t_ns, input real per_ns);
      int c;
      c = $rtoi(t_ns / per_ns);
      if ($itor(c) * per_ns < t_ns) c = c + 1;
      if (c < 1) c = 1;
      return c;
   endfunction

   // Longest time to cycles: round down, never below one
   function automatic int max_cycles(input real t_ns, input real per_ns);
      int c;
      c = $rtoi(t_ns / per_ns);
      if (c < 1) c = 1;
      return c;
   endfunction

endpackage

// ==== ddt_evt_if.sv ====
`timescale 1ns/1ps
// Toggle-coded events passing from the link clock to the system clock
interface ddt_evt_if #(
   parameter int W = 2
);
   logic [W-1:0] tgl;
   logic [W-1:0] pulse;
   modport tx (output tgl, input pulse);
   modport rx (input tgl, output pulse);
endinterface

// ==== ddt_sync.sv ====
`timescale 1ns/1ps
// Two-stage level synchroniser; only the second stage is visible
module ddt_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage feeds the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ==== ddt_evt_rx.sv ====
`timescale 1ns/1ps
// Receives toggle events and turns each change into a one-cycle pulse
module ddt_evt_rx #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   ddt_evt_if.rx    ev
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] last_r;

   // Edge detector looks only at the second and third stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
         last_r <= '0;
      end else begin
         meta_r <= ev.tgl;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign ev.pulse = sync_r ^ last_r;
endmodule

// ==== ddt_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Write termination starts write_latency minus 2 cycles after the write.
// - Chopped burst: nominal back 4 plus turn-off latency cycles after write.
// - Full burst: nominal back 6 plus turn-off latency cycles after write.
// - Leveling feedback appears within 7.5 ns or 7 ns of the strobe edge; at the 30 ns clock the code drives it on the fourth link edge after the strobe.
// - Feedback lanes may differ by up to 2 ns; controller tolerates it.
// - Cycle limits count real input clock edges, not elapsed time.
module ddt_top
   import ddt_pkg::*;
#(
   parameter int  DQ_W          = 8,
   parameter int  WL_W          = 5,
   parameter bit  GRADE_2133    = 1'b0,
   parameter real CK_PERIOD_NS  = 30.0
) (
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic            ck,
   input  wire logic            odt,
   input  wire logic            wr_cmd,
   input  wire logic            wr_chop,
   input  wire logic [WL_W-1:0] write_latency,
   input  wire logic            lvl_mode,
   input  wire logic            dll_en,
   input  wire logic            dqs,
   input  wire logic            ck_at_dqs,
   input  wire logic            viol_clear,
   output ddt_term_t            term_sel,
   output logic      [DQ_W-1:0] lvl_fb_dq_o,
   output logic      [DQ_W-1:0] lvl_fb_dq_oe,
   output logic                 viol_odt_short,
   output logic                 viol_lvl_early,
   output logic                 lvl_active_sts,
   output logic                 timing_unwarranted
);

   // ----------------------------------------------------------------------
   // Derived cycle counts
   // ----------------------------------------------------------------------
   // The feedback delay is a maximum and so rounds down; the strobe wait is
   // judged at the detector, which sits behind the pad synchroniser
   localparam real LVL_FB_NS  = GRADE_2133 ? LVL_FB_2133_NS : LVL_FB_1866_NS;
   localparam int  LVL_FB_CYC = max_cycles(LVL_FB_NS, CK_PERIOD_NS);
   localparam int  CW         = 6;
   localparam int  FB_W       = $clog2(LVL_FB_CYC + 1);
   localparam logic [CW-1:0]   ODT_MIN_C  = CW'(ODT_MIN_HIGH_CK);
   localparam logic [CW-1:0]   LVL_WAIT_C = CW'(LVL_FIRST_STROBE_CK + PAD_SYNC_CK);
   localparam logic [FB_W-1:0] FB_LAST_C  = FB_W'(LVL_FB_CYC);
   localparam logic [FB_W-1:0] FB_ONE_C   = FB_W'(1);
   localparam logic [CW-1:0]   ONE_C      = 6'h1;

   // Resting termination for a given enable level; one decode serves both
   // the idle path and the end of a write window
   function automatic ddt_term_t rest_of(input logic en);
      return en ? DDT_TERM_NOM : DDT_TERM_OFF;
   endfunction

   // ----------------------------------------------------------------------
   // Strobe and sampled clock from the pads, into the link domain
   // ----------------------------------------------------------------------
   logic [1:0] pad_s;
   logic       dqs_last_r;

   // Strobe and sampled clock share one synchroniser, so the level that a
   // strobe carries reaches the detector in the same cycle as the strobe
   ddt_sync #(.W(2)) u_pad_sync (
      .clk   (ck),
      .rst_n (rst_n),
      .d     ({ck_at_dqs, dqs}),
      .q     (pad_s)
   );

   // Rising edge of the synchronised strobe, one link cycle wide
   wire dqs_s      = pad_s[0];
   wire ck_samp_s  = pad_s[1];
   wire dqs_rise   = dqs_s & ~dqs_last_r;

   // ----------------------------------------------------------------------
   // Dynamic termination sequencer (link domain)
   // ----------------------------------------------------------------------
   // Six-bit window counter: the latest return, latency 31 with a full
   // burst, lands on edge 35, so the count never wraps inside a window
   ddt_term_t     term_r;
   ddt_term_t     term_nxt;
   logic          wr_on_r;
   logic          wr_on_nxt;
   logic          chop_r;
   logic [CW-1:0] wr_cnt_r;

   // Switch points, counted in link edges from the write
   wire [CW-1:0] wl_w       = CW'(write_latency);
   wire [CW-1:0] nom_to_wr  = wl_w - CW'(NOM_TO_WR_SUB_CK);
   wire [CW-1:0] turnoff_w  = wl_w - CW'(TURNOFF_SUB_CK);
   wire [CW-1:0] chop_end   = turnoff_w + CW'(WR_TO_NOM_CHOP_CK);
   wire [CW-1:0] full_end   = turnoff_w + CW'(WR_TO_NOM_FULL_CK);
   wire [CW-1:0] wr_to_nom  = chop_r ? chop_end : full_end;
   wire          wr_start   = wr_cmd & odt;
   wire          hit_wr     = wr_on_r && (wr_cnt_r == nom_to_wr);
   wire          hit_nom    = wr_on_r && (wr_cnt_r == wr_to_nom);
   wire          rest_term  = odt;

   // Next termination; a fresh write restarts the window without a glitch
   always_comb begin
      term_nxt  = term_r;
      wr_on_nxt = wr_on_r;
      if (hit_nom) begin
         term_nxt  = rest_of(rest_term);
         wr_on_nxt = 1'b0;
      end else if (hit_wr) begin
         term_nxt  = DDT_TERM_WR;
      end else if (term_r != DDT_TERM_WR) begin
         term_nxt  = rest_of(rest_term);
      end
      if (wr_start) begin
         wr_on_nxt = 1'b1;
      end
   end

   // Counter value is one more than the number of link edges since the write edge
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         term_r   <= DDT_TERM_OFF;
         wr_on_r  <= 1'b0;
         chop_r   <= 1'b0;
         wr_cnt_r <= '0;
      end else begin
         term_r  <= term_nxt;
         wr_on_r <= wr_on_nxt;
         if (wr_start) begin
            chop_r   <= wr_chop;
            wr_cnt_r <= ONE_C;
         end else if (wr_on_r) begin
            wr_cnt_r <= wr_cnt_r + ONE_C;
         end
      end
   end

   // Output straight from the register, so the pads never see a decode glitch
   assign term_sel = term_r;

   // ----------------------------------------------------------------------
   // Termination-enable high-time watch (link domain)
   // ----------------------------------------------------------------------
   // A full-burst write in the same high period brings a longer minimum
   // that is not watched here, so the short-pulse check stands down
   logic          odt_last_r;
   logic [CW-1:0] odt_hi_r;
   logic          odt_full_r;

   // A falling enable closes a high period; its length is judged then
   wire odt_fall  = odt_last_r & ~odt;
   wire odt_short = odt_fall && (odt_hi_r < ODT_MIN_C) && !odt_full_r;

   // Count saturates at the limit; a full-burst write lifts the check
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         odt_last_r <= 1'b0;
         odt_hi_r   <= '0;
         odt_full_r <= 1'b0;
      end else begin
         odt_last_r <= odt;
         if (!odt) begin
            odt_hi_r   <= '0;
            odt_full_r <= 1'b0;
         end else begin
            if (odt_hi_r < ODT_MIN_C) odt_hi_r <= odt_hi_r + ONE_C;
            if (wr_cmd && !wr_chop) odt_full_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Write leveling: first strobe wait and feedback (link domain)
   // ----------------------------------------------------------------------
   // The detector sees a pin edge two cycles late, so the wait limit carries
   // the same two cycles and a lawful first strobe is never flagged
   logic            lvl_r;
   logic [CW-1:0]   lvl_cnt_r;
   logic            lvl_seen_r;
   logic            fb_pend_r;
   logic [FB_W-1:0] fb_cnt_r;
   logic            fb_val_r;
   logic            fb_bit_r;

   // Only a strobe in leveling mode starts a feedback cycle
   wire lvl_strobe = lvl_mode & dqs_rise;
   wire lvl_early  = lvl_strobe && !lvl_seen_r && (lvl_cnt_r < LVL_WAIT_C);
   wire fb_due     = fb_pend_r && (fb_cnt_r == FB_LAST_C);

   // Wait count restarts whenever leveling is entered
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         lvl_r      <= 1'b0;
         lvl_cnt_r  <= '0;
         lvl_seen_r <= 1'b0;
         dqs_last_r <= 1'b0;
      end else begin
         lvl_r      <= lvl_mode;
         dqs_last_r <= dqs_s;
         if (!lvl_mode) begin
            lvl_cnt_r  <= '0;
            lvl_seen_r <= 1'b0;
         end else begin
            if (lvl_cnt_r < LVL_WAIT_C) lvl_cnt_r <= lvl_cnt_r + ONE_C;
            if (dqs_rise) lvl_seen_r <= 1'b1;
         end
      end
   end

   // Feedback is held back LVL_FB_CYC cycles: the longest allowed delay rounded down, but never below one cycle
   // A new strobe restarts the delay; leaving leveling clears the lanes
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         fb_pend_r <= 1'b0;
         fb_cnt_r  <= '0;
         fb_val_r  <= 1'b0;
         fb_bit_r  <= 1'b0;
      end else begin
         if (lvl_strobe) begin
            fb_pend_r <= 1'b1;
            fb_cnt_r  <= FB_ONE_C;
            fb_val_r  <= ck_samp_s;
         end else if (fb_due) begin
            fb_pend_r <= 1'b0;
            fb_bit_r  <= fb_val_r;
         end else if (fb_pend_r) begin
            fb_cnt_r  <= fb_cnt_r + FB_ONE_C;
         end
         if (!lvl_mode) fb_bit_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Lane fan-out
   // ----------------------------------------------------------------------
   // One flop feeds every lane, so lanes leave together; skew stays inside spread
   genvar ln;
   for (ln = 0; ln < DQ_W; ln++) begin : g_lane
      assign lvl_fb_dq_o[ln]  = fb_bit_r;
      assign lvl_fb_dq_oe[ln] = lvl_r;                                    // Drive while leveling
   end

   // ----------------------------------------------------------------------
   // Crossing to the system clock
   // ----------------------------------------------------------------------
   // Only toggles and slow levels cross; no multi-bit value crosses as a
   // word, so each bit may land a cycle apart from the other without harm
   logic [1:0] ev_tgl_r;
   logic       dll_off_r;
   logic [1:0] lvl_s;
   logic [1:0] viol_r;

   ddt_evt_if #(.W(2)) u_ev ();

   // Events travel as toggles, so none is lost to the slower clock
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         ev_tgl_r  <= '0;
         dll_off_r <= 1'b0;
      end else begin
         ev_tgl_r  <= ev_tgl_r ^ {lvl_early, odt_short};
         dll_off_r <= ~dll_en;
      end
   end

   assign u_ev.tgl = ev_tgl_r;

   // Toggles become one-cycle pulses on the system clock
   ddt_evt_rx #(.W(2)) u_ev_rx (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .ev    (u_ev)
   );

   // Mode and delay-loop levels need only a plain level synchroniser
   ddt_sync #(.W(2)) u_lvl_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({dll_off_r, lvl_r}),
      .q     (lvl_s)
   );

   // Sticky flags; an arriving event beats a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         viol_r <= '0;
      end else begin
         viol_r <= (viol_r & ~{2{viol_clear}}) | u_ev.pulse;
      end
   end

   // Status outputs straight from system-clock registers
   assign viol_odt_short     = viol_r[0];
   assign viol_lvl_early     = viol_r[1];
   assign lvl_active_sts     = lvl_s[0];
   assign timing_unwarranted = lvl_s[1];

endmodule

// ==== ddt_top_checker.sv ====
`timescale 1ns/1ps
module ddt_top_checker
   import ddt_pkg::*;
#(
   parameter int DQ_W = 8,
   parameter int WL_W = 5
) (
   input wire logic            ref_clk,
   input wire logic            rst_n,
   input wire logic            ck,
   input wire logic            odt,
   input wire logic            wr_cmd,
   input wire logic            wr_chop,
   input wire logic [WL_W-1:0] write_latency,
   input wire logic            lvl_mode,
   input wire logic            dll_en,
   input wire logic            dqs,
   input wire logic            ck_at_dqs,
   input wire logic            viol_clear,
   input wire ddt_term_t       term_sel,
   input wire logic [DQ_W-1:0] lvl_fb_dq_o,
   input wire logic [DQ_W-1:0] lvl_fb_dq_oe,
   input wire logic            viol_odt_short,
   input wire logic            viol_lvl_early,
   input wire logic            lvl_active_sts,
   input wire logic            timing_unwarranted
);
   logic [5:0] age_r;
   logic       act_r;
   logic       chop_r;
   wire  [5:0] wl_ext = 6'(write_latency);
   wire  [5:0] wr_end = wl_ext + (chop_r ? 6'h03 : 6'h05);
   // Age of the last write; dropped after its window so a new latency cannot alias
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         age_r  <= 6'h00;
         act_r  <= 1'b0;
         chop_r <= 1'b0;
      end else if (wr_cmd && odt) begin
         age_r  <= 6'h01;
         act_r  <= 1'b1;
         chop_r <= wr_chop;
      end else if (act_r) begin
         age_r <= age_r + 6'h01;
         act_r <= (age_r <= wr_end);
      end
   end
   a_wr_term_start: assert property (
      @(posedge ck) disable iff (!rst_n) act_r && age_r == wl_ext - 6'h01 |-> term_sel == DDT_TERM_WR)
      else $error("write termination late");
   a_wr_term_hold: assert property (
      @(posedge ck) disable iff (!rst_n)
      act_r && age_r >= wl_ext && age_r < wr_end |-> term_sel == DDT_TERM_WR)
      else $error("write termination dropped early");
   a_chop_return: assert property (
      @(posedge ck) disable iff (!rst_n) act_r && chop_r && age_r == wr_end
      |-> term_sel == ($past(odt) ? DDT_TERM_NOM : DDT_TERM_OFF))
      else $error("chopped burst return wrong");
   a_full_return: assert property (
      @(posedge ck) disable iff (!rst_n) act_r && !chop_r && age_r == wr_end
      |-> term_sel == ($past(odt) ? DDT_TERM_NOM : DDT_TERM_OFF))
      else $error("full burst return wrong");
   a_term_follow: assert property (
      @(posedge ck) disable iff (!rst_n)
      !act_r |-> term_sel == ($past(odt) ? DDT_TERM_NOM : DDT_TERM_OFF))
      else $error("termination does not follow enable");
   a_lvl_drive_oe: assert property (
      @(posedge ck) disable iff (!rst_n) lvl_fb_dq_oe == {DQ_W{$past(lvl_mode)}})
      else $error("feedback drive enable wrong");
   a_lvl_fb_time: assert property (
      @(posedge ck) disable iff (!rst_n)
      lvl_mode && $rose(dqs) |-> ##4 lvl_fb_dq_o == {DQ_W{ck_at_dqs}})
      else $error("leveling feedback mistimed");
   a_lvl_lanes_same: assert property (
      @(posedge ck) disable iff (!rst_n) lvl_fb_dq_o == {DQ_W{lvl_fb_dq_o[0]}})
      else $error("feedback lanes differ");
   a_odt_flag_sticky: assert property (
      @(posedge ref_clk) disable iff (!rst_n) viol_odt_short && !viol_clear |=> viol_odt_short)
      else $error("odt flag lost");
   a_lvl_flag_sticky: assert property (
      @(posedge ref_clk) disable iff (!rst_n) viol_lvl_early && !viol_clear |=> viol_lvl_early)
      else $error("leveling flag lost");
   a_dll_off_seen: assert property (
      @(posedge ref_clk) disable iff (!rst_n) $fell(dll_en) |-> ##[1:4] timing_unwarranted)
      else $error("dll off not reported");
endmodule
bind ddt_top ddt_top_checker #(.DQ_W(DQ_W), .WL_W(WL_W)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .ck(ck), .odt(odt), .wr_cmd(wr_cmd), .wr_chop(wr_chop),
   .write_latency(write_latency), .lvl_mode(lvl_mode), .dll_en(dll_en), .dqs(dqs),
   .ck_at_dqs(ck_at_dqs), .viol_clear(viol_clear), .term_sel(term_sel),
   .lvl_fb_dq_o(lvl_fb_dq_o), .lvl_fb_dq_oe(lvl_fb_dq_oe), .viol_odt_short(viol_odt_short),
   .viol_lvl_early(viol_lvl_early), .lvl_active_sts(lvl_active_sts),
   .timing_unwarranted(timing_unwarranted));

// ==== ddt_lvl_ctrl.sv ====
`timescale 1ns/1ps
// Controller leveling side: one strobe, then the feedback is sampled
module ddt_lvl_ctrl #(
   parameter int DQ_W  = 8,
   parameter int CK_PS = 30000
) (
   input  wire logic            ck,
   input  wire logic            start,
   input  wire logic            early,
   input  wire logic            level_bit,
   input  wire logic [DQ_W-1:0] fb,
   output logic                 lvl_mode,
   output logic                 dqs,
   output logic                 ck_at_dqs,
   output logic                 done,
   output logic                 fb_ok
);
   // Delay plus spread rounded up to clocks, plus device sync stages
   localparam int FB_CK = (7500 + 2000 + CK_PS - 1) / CK_PS + 5;
   initial begin
      {lvl_mode, dqs, ck_at_dqs, done, fb_ok} = 5'h00;
   end
   // Waits count real clock edges; early is only used when commanded
   always @(posedge start) begin
      @(posedge ck) #2 lvl_mode = 1'b1;
      repeat (early ? 10 : 41) @(posedge ck);
      #2 ck_at_dqs = level_bit;
      dqs = 1'b1;
      repeat (2) @(posedge ck);
      #2 dqs = 1'b0;
      repeat (FB_CK) @(posedge ck);
      #2 fb_ok = (fb === {DQ_W{level_bit}});
      lvl_mode = 1'b0;
      done = 1'b1;
      wait (!start);
      done = 1'b0;
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import ddt_pkg::*;
   localparam int DQ_W = 8;
   localparam int WL_W = 5;
   logic            ref_clk = 1'b0;
   logic            ck = 1'b0;
   logic            rst_n = 1'b0;
   logic            odt = 1'b0;
   logic            wr_cmd = 1'b0;
   logic            wr_chop = 1'b0;
   logic            dll_en = 1'b1;
   logic            viol_clear = 1'b0;
   logic            lvl_start = 1'b0;
   logic            lvl_early = 1'b0;
   logic            lvl_bit = 1'b0;
   logic [WL_W-1:0] write_latency = 5'h05;
   logic            lvl_mode, dqs, ck_at_dqs, lvl_done, lvl_ok;
   ddt_term_t       term_sel;
   logic [DQ_W-1:0] fb_dq, fb_oe;
   logic            v_odt, v_lvl, lvl_sts, t_unw;
   int              fail_count = 0;
   int              check_count = 0;
   int              cyc = 0;
   int              seed = 32'h06f2_b9d6;
   // Offset link clock so its edges never meet ref_clk edges
   always #10 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #15 ck = ~ck;
   end
   ddt_top #(.DQ_W(DQ_W), .WL_W(WL_W), .GRADE_2133(1'b0), .CK_PERIOD_NS(30.0)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .ck(ck), .odt(odt), .wr_cmd(wr_cmd), .wr_chop(wr_chop),
      .write_latency(write_latency), .lvl_mode(lvl_mode), .dll_en(dll_en), .dqs(dqs),
      .ck_at_dqs(ck_at_dqs), .viol_clear(viol_clear), .term_sel(term_sel), .lvl_fb_dq_o(fb_dq),
      .lvl_fb_dq_oe(fb_oe), .viol_odt_short(v_odt), .viol_lvl_early(v_lvl),
      .lvl_active_sts(lvl_sts), .timing_unwarranted(t_unw));
   ddt_lvl_ctrl #(.DQ_W(DQ_W), .CK_PS(30000)) u_ctrl (.ck(ck), .start(lvl_start),
      .early(lvl_early), .level_bit(lvl_bit), .fb(fb_dq), .lvl_mode(lvl_mode), .dqs(dqs),
      .ck_at_dqs(ck_at_dqs), .done(lvl_done), .fb_ok(lvl_ok));
   // Hang guard: the whole run needs well under 2000 ref_clk cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         $display("MISMATCH %0t timeout", $time);
         end_sim();
      end
   end
   task step();
      @(posedge ck);
      #2;
   endtask
   task check(input bit ok, input string what);
      check_count++;
      if (!ok) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   // Expected termination k edges after the write edge
   function automatic ddt_term_t exp_term(input int k, input int wl, input bit chop, input bit o);
      if (o && k >= wl - NOM_TO_WR_SUB_CK &&
          k < wl - TURNOFF_SUB_CK + (chop ? WR_TO_NOM_CHOP_CK : WR_TO_NOM_FULL_CK))
         return DDT_TERM_WR;
      return o ? DDT_TERM_NOM : DDT_TERM_OFF;
   endfunction
   // Optional first write one edge before, so the second must restart the count
   task automatic do_write(input int wl, input bit chop, input bit o, input bit b2b);
      write_latency = WL_W'(wl);
      odt = o;
      repeat (2) step();
      wr_cmd = 1'b1;
      wr_chop = ~chop;
      if (b2b) step();
      wr_chop = chop;
      step();
      wr_cmd = 1'b0;
      for (int k = 1; k <= wl + 8; k++) begin
         step();
         check(term_sel === exp_term(k, wl, chop, o), "termination value");
      end
      odt = 1'b0;
      step();
   endtask
   task clear_viol();
      @(posedge ref_clk) #2 viol_clear = 1'b1;
      @(posedge ref_clk) #2 viol_clear = 1'b0;
      step();
      check(v_odt === 1'b0 && v_lvl === 1'b0, "flags not cleared");
   endtask
   // A full-burst write inside the high period lifts the minimum-width flag
   task odt_pulse(input int n, input bit full, input bit exp);
      odt = 1'b1;
      wr_cmd = full;
      wr_chop = 1'b0;
      step();
      wr_cmd = 1'b0;
      repeat (n - 1) step();
      odt = 1'b0;
      repeat (8) step();
      check(v_odt === exp, "odt width flag");
      clear_viol();
   endtask
   task automatic lvl_run(input bit early);
      int n;
      lvl_early = early;
      lvl_bit = 1'($random(seed));
      lvl_start = 1'b1;
      for (n = 0; n < 200 && lvl_done !== 1'b1; n++) step();
      check(lvl_done === 1'b1 && lvl_sts === 1'b1, "leveling incomplete");
      check(lvl_ok === 1'b1, "leveling feedback wrong");
      check(v_lvl === early, "early strobe flag");
      lvl_start = 1'b0;
      repeat (8) step();
      clear_viol();
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Latency corners, back-to-back, refused write, random writes, then the monitors
   initial begin
      repeat (2) step();
      rst_n = 1'b1;
      repeat (2) step();
      do_write(3, 1'b1, 1'b1, 1'b0);
      do_write(31, 1'b0, 1'b1, 1'b0);
      do_write(5, 1'b0, 1'b1, 1'b1);
      do_write(7, 1'b1, 1'b0, 1'b0);
      repeat (4) do_write(3 + int'($unsigned($random(seed)) % 29), 1'($random(seed)), 1'b1, 1'b0);
      $display("test termination done");
      odt_pulse(2, 1'b0, 1'b1);
      odt_pulse(4, 1'b0, 1'b0);
      odt_pulse(2, 1'b1, 1'b0);
      $display("test odt width done");
      lvl_run(1'b0);
      lvl_run(1'b1);
      $display("test leveling done");
      dll_en = 1'b0;
      repeat (6) step();
      check(t_unw === 1'b1, "dll off not reported");
      dll_en = 1'b1;
      repeat (6) step();
      check(t_unw === 1'b0, "dll on not reported");
      $display("test dll done");
      end_sim();
   end
endmodule
